// File: dac_config_status_regs.sv
// Operation
// (RULE1) Host writes zero to no-operation; nothing happens
// (RULE2) Identification register read-only: identifier plus revision
// (RULE3) Status bit 2 reports frame check error
// (RULE4) Status bit 1 shows converters busy updating
// (RULE5) Status bit 0 reports die over temperature
// (RULE6) Over temperature forces both converters off
// (RULE7) Config bit 11 routes over temperature to fault
// (RULE8) Config bit 10 routes update busy to fault
// (RULE9) Busy fault self-clears; other alarms stay latched
// (RULE10) Config bit 9 routes frame errors to fault
// (RULE11) Config bit 5 puts device to sleep
// (RULE12) Config bit 4 enables frame checking, reset off
// (RULE13) Config bit 2 enables serial data output
// (RULE14) Config bit 1 selects falling launch edge
// (RULE15) General config bit 14 sleeps the reference
// (RULE16) Reserved fields read fixed reset values only
// (RULE17) Read data arrives during the following frame
// (RULE18) Failed frame sets alarm and drives fault low
// (RULE19) Reset loads every register reset value
// (RULE20) Frame and temperature alarms latch until cleared
`include "dac_regs_params.svh"

module dac_config_status_regs
	import dac_regs_pkg::*;
#(
	parameter logic [13:0] PART_IDENTIFIER = 14'h0123, // Arbitrary value
	parameter logic [1:0] SILICON_REVISION = `SILICON_REVISION_RESET
) (
	input wire logic ref_clk, // Core clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic sclk, // Serial link clock
	input wire logic sync_n, // Frame select, active low
	input wire logic sdi, // Serial data in
	output logic sdo, // Serial data out
	output logic sdo_oe, // Serial data out enable
	input wire logic overtemp_detect, // Temperature detector, asynchronous
	input wire logic update_busy, // Converters not ready for updates
	input wire logic alarm_clear, // Alarm reset command pulse
	output logic alarm_output_pin_n, // Fault output, active low
	output logic device_sleep, // Whole device in power-down
	output logic reference_sleep, // Internal reference powered down
	output logic converters_forced_off // Both outputs forced to power-down
);
	logic [15:0] iface_q;
	logic [15:0] gen_q;
	logic crc_alarm_q;
	logic overtemp_q;
	logic seen_q;
	link_word_t resp_q;
	link_word_t rx_word;
	logic rx_toggle;
	logic toggle_s;
	logic overtemp_s;
	logic frame_evt;
	logic check_on;
	cmd_frame_t cmd;
	logic bad;
	logic wr_ok;
	logic [15:0] iface_rd;
	logic [15:0] gen_rd;
	logic [15:0] flags_rd;

	frame_link u_link (
		.sclk(sclk),
		.rst(rst),
		.sync_n(sync_n),
		.sdi(sdi),
		.check_mode(iface_q[`FRAME_CHECK_ENABLE_BIT]),
		.out_enable(iface_q[`SERIAL_OUT_ENABLE_BIT]),
		.early_edge(iface_q[`EARLY_OUTPUT_EDGE_BIT]),
		.resp(resp_q),
		.rx_word(rx_word),
		.rx_toggle(rx_toggle),
		.sdo(sdo),
		.sdo_oe(sdo_oe)
	);

	bit_sync u_tog (.clk(ref_clk), .din(rx_toggle), .dout(toggle_s));
	bit_sync u_temp (.clk(ref_clk), .din(overtemp_detect), .dout(overtemp_s));

	// Frame word is stable once its toggle has crossed
	assign frame_evt = toggle_s != seen_q;
	assign check_on = iface_q[`FRAME_CHECK_ENABLE_BIT];
	assign cmd = check_on ? rx_word.cmd : cmd_frame_t'(rx_word[23:0]);
	assign bad = check_on && (frame_check(cmd) != rx_word.check); // RULE12
	assign wr_ok = frame_evt && !bad && !cmd.rw;

	// Reserved bits always read their fixed values
	assign iface_rd = (iface_q & `IFACE_CFG_WMASK) | (`IFACE_CFG_RESET & ~`IFACE_CFG_WMASK); // RULE16
	assign gen_rd = (gen_q & `GEN_CFG_WMASK) | (`GEN_CFG_RESET & ~`GEN_CFG_WMASK); // RULE16

	always_comb begin
		flags_rd = `ALARM_FLAGS_RESET;
		flags_rd[`FRAME_CHECK_ALARM_BIT] = crc_alarm_q; // RULE3
		flags_rd[`UPDATE_BUSY_BIT] = update_busy; // RULE4
		flags_rd[`OVERTEMP_ALARM_BIT] = overtemp_q; // RULE5
	end

	function automatic logic [15:0] read_data(input logic [5:0] a);
		unique case (a)
			`ADDR_PART_ID: return {PART_IDENTIFIER, SILICON_REVISION}; // RULE2
			`ADDR_ALARM_FLAGS: return flags_rd;
			`ADDR_IFACE_CFG: return iface_rd;
			`ADDR_GEN_CFG: return gen_rd;
			default: return 16'h0000;
		endcase
	endfunction : read_data

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= toggle_s;
		end
	end

	// Only the two configuration registers take writes; no-op and
	// identification writes fall through untouched
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			iface_q <= `IFACE_CFG_RESET & `IFACE_CFG_WMASK; // RULE19
			gen_q <= `GEN_CFG_RESET & `GEN_CFG_WMASK; // RULE19
		end else if (wr_ok) begin
			unique case (cmd.addr)
				`ADDR_IFACE_CFG: iface_q <= cmd.data & `IFACE_CFG_WMASK; // RULE11
				`ADDR_GEN_CFG: gen_q <= cmd.data & `GEN_CFG_WMASK; // RULE15
				default: ; // RULE1 RULE2
			endcase
		end
	end

	// Latched alarms; a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			crc_alarm_q <= 1'b0;
		end else if (frame_evt && bad) begin
			crc_alarm_q <= 1'b1; // RULE18
		end else if (alarm_clear) begin
			crc_alarm_q <= 1'b0; // RULE20
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			overtemp_q <= 1'b0;
		end else if (overtemp_s) begin
			overtemp_q <= 1'b1; // RULE5
		end else if (alarm_clear) begin
			overtemp_q <= 1'b0; // RULE20
		end
	end

	// Answer shifted out during the next frame
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			resp_q <= '0;
		end else if (frame_evt) begin
			resp_q.cmd.rw <= cmd.rw;
			resp_q.cmd.spare <= bad;
			resp_q.cmd.addr <= cmd.addr;
			resp_q.cmd.data <= cmd.rw ? read_data(cmd.addr) : cmd.data; // RULE17
			resp_q.check <= frame_check('{cmd.rw, bad, cmd.addr,
				cmd.rw ? read_data(cmd.addr) : cmd.data});
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			alarm_output_pin_n <= 1'b1;
		end else begin
			alarm_output_pin_n <= !(
				(iface_q[`OVERTEMP_FAULT_ENABLE_BIT] && overtemp_q) || // RULE7
				(iface_q[`UPDATE_BUSY_FAULT_ENABLE_BIT] && update_busy) || // RULE8 RULE9
				(iface_q[`FRAME_CHECK_FAULT_ENABLE_BIT] && crc_alarm_q)); // RULE10 RULE18
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			device_sleep <= 1'(`IFACE_CFG_RESET >> `DEVICE_SLEEP_BIT);
			reference_sleep <= 1'(`GEN_CFG_RESET >> `REFERENCE_SLEEP_BIT);
			converters_forced_off <= 1'b0;
		end else begin
			device_sleep <= iface_q[`DEVICE_SLEEP_BIT]; // RULE11
			reference_sleep <= gen_q[`REFERENCE_SLEEP_BIT]; // RULE15
			converters_forced_off <= overtemp_q; // RULE6
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_bad_frame;
		frame_evt && bad;
	endsequence

	sequence s_read_of(logic [5:0] a);
		frame_evt && !bad && cmd.rw && cmd.addr == a;
	endsequence

	chk_id_read: assert property (s_read_of(`ADDR_PART_ID) |=> // RULE2
		resp_q.cmd.data == {PART_IDENTIFIER, SILICON_REVISION})
		else $error("identification readback wrong");

	chk_frame_alarm: assert property (s_bad_frame |=> crc_alarm_q ##1 !alarm_output_pin_n // RULE3
		|| !iface_q[`FRAME_CHECK_FAULT_ENABLE_BIT])
		else $error("frame check alarm not raised");

	chk_bad_no_write: assert property (s_bad_frame |=> $stable(iface_q) && $stable(gen_q)) // RULE18
		else $error("failed frame changed a register");

	chk_busy_read: assert property (s_read_of(`ADDR_ALARM_FLAGS) && update_busy |=> // RULE4
		resp_q.cmd.data[`UPDATE_BUSY_BIT])
		else $error("busy flag not reported");

	chk_temp_latch: assert property (overtemp_s |=> overtemp_q ##1 converters_forced_off) // RULE5
		else $error("over temperature not latched");

	chk_forced_off: assert property (overtemp_q |=> converters_forced_off) // RULE6
		else $error("converters not forced off");

	chk_temp_fault: assert property (overtemp_q && iface_q[`OVERTEMP_FAULT_ENABLE_BIT] |=> // RULE7
		!alarm_output_pin_n)
		else $error("temperature fault missing");

	chk_busy_fault: assert property (update_busy && iface_q[`UPDATE_BUSY_FAULT_ENABLE_BIT] |=> // RULE8
		!alarm_output_pin_n)
		else $error("busy fault missing");

	chk_fault_release: assert property (!update_busy && !overtemp_q && !crc_alarm_q |=> // RULE9
		alarm_output_pin_n)
		else $error("fault stays without a cause");

	chk_check_fault: assert property (crc_alarm_q && iface_q[`FRAME_CHECK_FAULT_ENABLE_BIT] |=> // RULE10
		!alarm_output_pin_n)
		else $error("frame check fault missing");

	chk_sleep_out: assert property (iface_q[`DEVICE_SLEEP_BIT] |=> device_sleep) // RULE11
		else $error("device sleep not driven");

	chk_check_off: assert property (frame_evt && !check_on && !cmd.rw && // RULE12
		cmd.addr == `ADDR_GEN_CFG |=>
		gen_q[`REFERENCE_SLEEP_BIT] == $past(cmd.data[`REFERENCE_SLEEP_BIT]))
		else $error("unchecked write not taken");

	chk_ref_sleep: assert property (1'b1 |=> // RULE15
		reference_sleep == $past(gen_q[`REFERENCE_SLEEP_BIT]))
		else $error("reference sleep mismatch");

	chk_reserved_bits: assert property (s_read_of(`ADDR_IFACE_CFG) |=> // RULE16
		resp_q.cmd.data[8:6] == 3'b010 && resp_q.cmd.data[15:12] == 4'h0)
		else $error("reserved field wrong");

	chk_reset_load: assert property (disable iff (1'b0) rst |=> // RULE19
		iface_rd == `IFACE_CFG_RESET && gen_rd == `GEN_CFG_RESET && flags_rd[2] == 1'b0)
		else $error("reset value not loaded");

	chk_alarm_sticky: assert property (crc_alarm_q && !alarm_clear |=> crc_alarm_q) // RULE20
		else $error("frame alarm dropped without clear");

	// Reserved fields and fixed registers
	chk_iface_fixed: assert property (iface_rd[15:12] == 4'h0 && // RULE16
		iface_rd[8:6] == 3'b010 && iface_rd[3] == 1'b0 && iface_rd[0] == 1'b0)
		else $error("interface reserved bits moved");

	chk_gen_fixed: assert property (gen_rd[15] == 1'b0 && gen_rd[13:0] == 14'h0000) // RULE16
		else $error("general reserved bits moved");

	chk_flags_fixed: assert property (flags_rd[15:3] == 13'h0000) // RULE16
		else $error("status reserved bits moved");

	chk_ro_write: assert property (wr_ok && cmd.addr <= `ADDR_ALARM_FLAGS |=> // RULE2
		$stable(iface_q) && $stable(gen_q))
		else $error("write to fixed register changed state");

	chk_clear_frame: assert property (alarm_clear && !(frame_evt && bad) |=> // RULE20
		!crc_alarm_q)
		else $error("frame alarm not cleared");

	chk_clear_temp: assert property (alarm_clear && !overtemp_s |=> !overtemp_q) // RULE20
		else $error("temperature alarm not cleared");

	chk_busy_masked: assert property (!iface_q[`UPDATE_BUSY_FAULT_ENABLE_BIT] && // RULE8
		!overtemp_q && !crc_alarm_q |=> alarm_output_pin_n)
		else $error("fault raised by masked busy");

	chk_write_echo: assert property (frame_evt && !bad && !cmd.rw |=> // RULE17
		resp_q.cmd.data == $past(cmd.data))
		else $error("write data not echoed");

	chk_check_code: assert property (frame_evt |=> resp_q.check == frame_check(resp_q.cmd)) // RULE17
		else $error("answer check code wrong");

	chk_error_echo: assert property (s_bad_frame |=> resp_q.cmd.spare) // RULE18
		else $error("frame error not echoed");

	chk_temp_status: assert property (s_read_of(`ADDR_ALARM_FLAGS) && overtemp_q |=> // RULE5
		resp_q.cmd.data[`OVERTEMP_ALARM_BIT])
		else $error("temperature flag not reported");

	chk_sleep_wake: assert property (!iface_q[`DEVICE_SLEEP_BIT] |=> !device_sleep) // RULE11
		else $error("device left asleep");

	chk_forced_release: assert property (!overtemp_q |=> !converters_forced_off) // RULE6
		else $error("converters held off without alarm");

endmodule : dac_config_status_regs

// File: dac_regs_params.svh
`ifndef DAC_REGS_PARAMS_SVH
`define DAC_REGS_PARAMS_SVH

// Register offsets on the serial link
`define ADDR_NO_OPERATION 6'h00
`define ADDR_PART_ID 6'h01
`define ADDR_ALARM_FLAGS 6'h02
`define ADDR_IFACE_CFG 6'h03
`define ADDR_GEN_CFG 6'h04

// Reset values
`define NO_OPERATION_RESET 16'h0000
`define ALARM_FLAGS_RESET 16'h0000
`define IFACE_CFG_RESET 16'h0AA4
`define GEN_CFG_RESET 16'h4000
`define SILICON_REVISION_RESET 2'h0

// Writable bit masks
`define IFACE_CFG_WMASK 16'h0E36
`define GEN_CFG_WMASK 16'h4000

// Field positions of interface_alarm_config
`define OVERTEMP_FAULT_ENABLE_BIT 11
`define UPDATE_BUSY_FAULT_ENABLE_BIT 10
`define FRAME_CHECK_FAULT_ENABLE_BIT 9
`define DEVICE_SLEEP_BIT 5
`define FRAME_CHECK_ENABLE_BIT 4
`define SERIAL_OUT_ENABLE_BIT 2
`define EARLY_OUTPUT_EDGE_BIT 1

// Field positions of general_config and alarm_flags
`define REFERENCE_SLEEP_BIT 14
`define FRAME_CHECK_ALARM_BIT 2
`define UPDATE_BUSY_BIT 1
`define OVERTEMP_ALARM_BIT 0

// Frame lengths in SCLK cycles and frame check polynomial
`define FRAME_BITS_PLAIN 6'd24
`define FRAME_BITS_CHECKED 6'd32
`define FRAME_CHECK_POLY 8'h07
`define FRAME_CHECK_INIT 8'h00

`endif

// File: dac_regs_pkg.sv
`include "dac_regs_params.svh"

package dac_regs_pkg;

	typedef struct packed {
		logic rw;
		logic spare;
		logic [5:0] addr;
		logic [15:0] data;
	} cmd_frame_t;

	typedef struct packed {
		cmd_frame_t cmd;
		logic [7:0] check;
	} link_word_t;

	// Frame check code over a command, MSB first
	function automatic logic [7:0] frame_check(input cmd_frame_t c);
		logic [7:0] r;
		logic [23:0] d;
		r = `FRAME_CHECK_INIT;
		d = c;
		for (int i = 23; i >= 0; i--) begin
			if (r[7] ^ d[i]) begin
				r = {r[6:0], 1'b0} ^ `FRAME_CHECK_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction : frame_check

endpackage : dac_regs_pkg

// File: bit_sync.sv
module bit_sync (
	input wire logic clk, // Destination clock
	input wire logic din, // Asynchronous level
	output logic dout // Synchronised level
);
	logic meta_q;

	always_ff @(posedge clk) begin
		meta_q <= din;
		dout <= meta_q;
	end

endmodule : bit_sync

// File: frame_link.sv
module frame_link
	import dac_regs_pkg::*;
(
	input wire logic sclk, // Link clock
	input wire logic rst, // Reset, used here as asynchronous clear
	input wire logic sync_n, // Frame select, low during a frame
	input wire logic sdi, // Serial data in
	input wire logic check_mode, // Frame check enabled, core domain level
	input wire logic out_enable, // Serial out enabled, core domain level
	input wire logic early_edge, // Launch on falling edges, core domain level
	input link_word_t resp, // Answer for the next frame, held stable
	output link_word_t rx_word, // Last complete frame
	output logic rx_toggle, // Flips once per complete frame
	output logic sdo, // Serial data out
	output logic sdo_oe // Serial data out enable
);
	logic frame_clr;
	logic check_s, out_en_s, early_s;
	logic [5:0] cnt_q;
	logic [31:0] shin_q;
	logic [31:0] tx_q;
	logic sdo_r_q, sdo_f_q, fell_q, oe_q;
	logic [5:0] last_bit;

	// Idle select ends frame state without needing an SCLK edge
	assign frame_clr = sync_n | rst;
	assign last_bit = check_s ? (`FRAME_BITS_CHECKED - 6'd1) : (`FRAME_BITS_PLAIN - 6'd1);

	bit_sync u_check (.clk(sclk), .din(check_mode), .dout(check_s));
	bit_sync u_oen (.clk(sclk), .din(out_enable), .dout(out_en_s));
	bit_sync u_early (.clk(sclk), .din(early_edge), .dout(early_s));

	always_ff @(posedge sclk or posedge frame_clr) begin
		if (frame_clr) begin
			cnt_q <= 6'h00;
			shin_q <= 32'h0000_0000;
			tx_q <= 32'h0000_0000;
			sdo_r_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			shin_q <= {shin_q[30:0], sdi};
			if (cnt_q != 6'h3F) begin
				cnt_q <= cnt_q + 6'd1;
			end
			oe_q <= out_en_s; // RULE13
			if (cnt_q == 6'h00) begin
				sdo_r_q <= resp[31];
				tx_q <= {resp[30:0], 1'b0};
			end else begin
				sdo_r_q <= tx_q[31];
				tx_q <= {tx_q[30:0], 1'b0};
			end
		end
	end

	// Falling-edge copy shows the next bit half a cycle sooner
	always_ff @(negedge sclk or posedge frame_clr) begin
		if (frame_clr) begin
			sdo_f_q <= 1'b0;
			fell_q <= 1'b0;
		end else begin
			sdo_f_q <= tx_q[31];
			fell_q <= 1'b1;
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rx_word <= '0;
			rx_toggle <= 1'b0;
		end else if (!sync_n && cnt_q == last_bit) begin
			rx_word <= {shin_q[30:0], sdi};
			rx_toggle <= ~rx_toggle;
		end
	end

	assign sdo = (early_s && fell_q) ? sdo_f_q : sdo_r_q; // RULE14
	assign sdo_oe = oe_q;

	chk_out_gate: assert property (@(posedge sclk) disable iff (frame_clr) // RULE13
		!out_en_s |=> !sdo_oe)
		else $error("serial out driven while disabled");

endmodule : frame_link

// File: spi_host_model.sv
module spi_host_model (
	output logic sclk, // Link clock, still outside frames
	output logic sync_n, // Frame select, active low
	output logic sdi, // Data to the device
	input wire logic sdo, // Data from the device
	input wire logic sdo_oe // Device drives sdo
);
	timeunit 1ns;
	timeprecision 10ps;
	logic oe_seen;
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		sdi = 1'b0;
		oe_seen = 1'b0;
	end
	// Sends the top nbits of word MSB first; sdo is sampled mid-high, valid in both edge modes
	task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] rx);
		rx = 32'h0;
		oe_seen = 1'b0;
		sync_n = 1'b0;
		for (int i = 31; i > 31 - nbits; i--) begin
			sdi = word[i];
			#7.5 sclk = 1'b1;
			// Undriven line reads as the inverse of the last bit
			#3.75 rx[i] = sdo_oe ? sdo : ~sdo;
			oe_seen = oe_seen | sdo_oe;
			#3.75 sclk = 1'b0;
		end
		#7.5 sync_n = 1'b1;
		// Released line must not keep showing the last bit
		sdi = ~sdi;
		// Gap so the answer is ready before the next frame
		#120;
	endtask : xfer
endmodule : spi_host_model

// File: test_dac_config_status_regs.sv
`include "dac_regs_params.svh"
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("[FAIL] %s expected %h seen %h", name, exp, got); end end

module test_dac_config_status_regs
	import dac_regs_pkg::*;
();
	timeunit 1ns;
	timeprecision 10ps;
	localparam logic [13:0] PART_ID = 14'h2A5B; // Arbitrary value
	logic ref_clk, rst, sclk, sync_n, sdi, sdo, sdo_oe;
	logic overtemp_detect, update_busy, alarm_clear, pin_n;
	logic device_sleep, reference_sleep, converters_forced_off, chk_on;
	int fails, checks_done;
	logic [31:0] rx;
	logic [15:0] rd_data;
	logic [5:0] w_addr [6] = '{6'h03, 6'h01, 6'h02, 6'h04, 6'h04, 6'h3F};
	logic [15:0] w_data [6] = '{16'hFFEF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF};
	logic [15:0] w_exp [6] = '{16'h0EA6, {PART_ID, 2'h0}, 16'h0000, 16'h4000, 16'h0000, 16'h0000};
	logic [5:0] r_addr [4] = '{6'h01, 6'h02, 6'h03, 6'h04};
	logic [15:0] r_exp [4] = '{{PART_ID, 2'h0}, 16'h0000, 16'h0AA4, 16'h4000};

	dac_config_status_regs #(.PART_IDENTIFIER(PART_ID)) dac_config_status_regs_i (
		.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .overtemp_detect(overtemp_detect),
		.update_busy(update_busy), .alarm_clear(alarm_clear),
		.alarm_output_pin_n(pin_n), .device_sleep(device_sleep),
		.reference_sleep(reference_sleep), .converters_forced_off(converters_forced_off));

	spi_host_model spi_host_model_i (
		.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

	always #4 ref_clk = ~ref_clk;

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic frame(input logic rw, input logic [5:0] a, input logic [15:0] d,
			input logic bad, output logic [31:0] ans);
		cmd_frame_t c;
		link_word_t w;
		c = '{rw: rw, spare: 1'b0, addr: a, data: d};
		w = '{cmd: c, check: frame_check(c) ^ {7'h00, bad}};
		spi_host_model_i.xfer(w, chk_on ? 32 : 24, ans);
		cyc(1);
	endtask : frame

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		frame(1'b0, a, d, 1'b0, rx);
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		frame(1'b1, a, 16'h0000, 1'b0, rx);
		wr(`ADDR_NO_OPERATION, `NO_OPERATION_RESET);
		d = rx[23:8];
	endtask : rd

	task automatic overtemp_event();
		overtemp_detect = 1'b1;
		cyc(5);
		overtemp_detect = 1'b0;
		cyc(2);
	endtask : overtemp_event

	task automatic clear_alarms();
		alarm_clear = 1'b1;
		cyc(1);
		alarm_clear = 1'b0;
		cyc(3);
	endtask : clear_alarms

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	initial begin
		#300us;
		fails++;
		$display("[FAIL] watchdog expected end seen hang");
		finish_test();
	end

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		{overtemp_detect, update_busy, alarm_clear, chk_on} = 4'h0;
		cyc(20);
		rst = 1'b0;
		`CHK("reset outputs", 5'b11100, {pin_n, device_sleep, reference_sleep,
			converters_forced_off, sdo_oe})
		cyc(4);
		for (int i = 0; i < 4; i++) begin
			rd(r_addr[i], rd_data);
			`CHK("reset value", r_exp[i], rd_data)
		end
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			wr(w_addr[i], w_data[i]);
			rd(w_addr[i], rd_data);
			`CHK("readback", w_exp[i], rd_data)
		end
		`CHK("reference sleep", 1'b0, reference_sleep)
		$display("access test done");
		wr(`ADDR_IFACE_CFG, 16'h0A80);
		`CHK("device sleep", 1'b0, device_sleep)
		// Enable reaches the link only after two link edges
		wr(`ADDR_NO_OPERATION, 16'h0000);
		wr(`ADDR_NO_OPERATION, 16'h0000);
		`CHK("sdo off", 1'b0, spi_host_model_i.oe_seen)
		wr(`ADDR_IFACE_CFG, 16'h0AA4);
		`CHK("device sleep", 1'b1, device_sleep)
		wr(`ADDR_NO_OPERATION, 16'h0000);
		`CHK("sdo on", 1'b1, spi_host_model_i.oe_seen)
		$display("config test done");
		wr(`ADDR_IFACE_CFG, 16'h0E84);
		update_busy = 1'b1;
		cyc(3);
		`CHK("busy fault", 1'b0, pin_n)
		rd(`ADDR_ALARM_FLAGS, rd_data);
		`CHK("busy status", 16'h0002, rd_data)
		update_busy = 1'b0;
		cyc(3);
		`CHK("busy release", 1'b1, pin_n)
		wr(`ADDR_IFACE_CFG, 16'h0A84);
		update_busy = 1'b1;
		cyc(3);
		`CHK("busy masked", 1'b1, pin_n)
		update_busy = 1'b0;
		$display("busy test done");
		overtemp_event();
		`CHK("overtemp pin", 1'b0, pin_n)
		`CHK("forced off", 1'b1, converters_forced_off)
		rd(`ADDR_ALARM_FLAGS, rd_data);
		`CHK("overtemp status", 16'h0001, rd_data)
		clear_alarms();
		`CHK("cleared", 2'b10, {pin_n, converters_forced_off})
		wr(`ADDR_IFACE_CFG, 16'h0284);
		overtemp_event();
		`CHK("overtemp masked", 2'b11, {pin_n, converters_forced_off})
		clear_alarms();
		$display("overtemp test done");
		wr(`ADDR_IFACE_CFG, 16'h0A94);
		chk_on = 1'b1;
		frame(1'b0, `ADDR_GEN_CFG, 16'h4000, 1'b1, rx);
		`CHK("frame fault", 1'b0, pin_n)
		frame(1'b1, `ADDR_ALARM_FLAGS, 16'h0000, 1'b0, rx);
		`CHK("error echo", 1'b1, rx[30])
		wr(`ADDR_NO_OPERATION, 16'h0000);
		`CHK("frame status", 16'h0004, rx[23:8])
		`CHK("refused write", 1'b0, reference_sleep)
		wr(`ADDR_GEN_CFG, 16'h4000);
		`CHK("checked write", 1'b1, reference_sleep)
		clear_alarms();
		`CHK("frame clear", 1'b1, pin_n)
		$display("frame check test done");
		finish_test();
	end
endmodule : test_dac_config_status_regs
